// File: rtl/power_event_defs.vh
`ifndef POWER_EVENT_DEFS_VH
`define POWER_EVENT_DEFS_VH

// power states
`define PS_NOSUPPLY         3'h0
`define PS_OFF              3'h1
`define PS_ACTIVE           3'h2
`define PS_SLEEP            3'h3
`define PS_BACKUP           3'h4

// clock period and charged-result debounce
`define CLK_PERIOD_NS       25
`define DEBOUNCE_NS         61000
`define DEBOUNCE_CYCLES     ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// enable hold window (cycles), default
`define HOLD_WINDOW_CYCLES  32'h0000_8000

// watchdog: period unit in cycles, setting width, reset setting (longest)
`define WDOG_UNIT_CYCLES    32'h0000_1000
`define WDOG_SEL_W          2
`define WDOG_SEL_RESET      2'h3

// threshold selection widths and reset values
`define THR_SEL_W           5
`define SECOND_SEL_RESET    5'h00

// power-down polarity after reset: 0 = active low
`define PD_POL_RESET        1'h0

// cause vector bits
`define CAUSE_W             5
`define CAUSE_POWER_DOWN_RESET_IN         0
`define CAUSE_WDOG          1
`define CAUSE_MAINHI        2
`define CAUSE_RISE2         3
`define CAUSE_FALL2         4

`endif

// File: rtl/power_event_supervisor.v
// Notes on behaviour
// - cold reset high holds off state, settings return to reset/boot values.
// - cold reset falling turns device active for hold window only.
// - power-down input at selected level forces off with power-off reset.
// - stay off until power-down released and a start-up reason appears.
// - flag power-down input as shutdown cause.
// - primary above high level: no-supply to off, set main-high flag.
// - primary below low level goes backup; both supplies gone goes no-supply.
// - off-to-active blocked while first comparator reports not charged.
// - charged result accepted after debounce period continuously above hysteresis.
// - charged threshold select zero bypasses first comparator check.
// - second comparator disabled until nonzero threshold select written.
// - second comparator sets rising or falling flag per programming.
// - second comparator wakes from sleep, turns on from off, idle in backup.
// - periodic watchdog flags each period, shuts down if still uncleared.
// - watchdog counter held at initial value while system reset low.
// - interrupt mode counts while interrupts pending, expiry turns off.
// - after reset watchdog is periodic with longest period.
// - tracking enable cleared on every turn-off.
// - pending interrupt counts as on-reason only in hold window while off.
// - power-down polarity resets to active low.
`timescale 1ns/1ps
`include "power_event_defs.vh"

module power_event_supervisor #(
    parameter HOLD_CYCLES = `HOLD_WINDOW_CYCLES,
    parameter WDOG_UNIT   = `WDOG_UNIT_CYCLES,
    parameter DEB_CYCLES  = `DEBOUNCE_CYCLES
) (
    input  wire                    clk,
    input  wire                    reset,
    input  wire                    coldResetIn,
    input  wire                    powerDownResetIn,
    input  wire                    powerButtonIn,
    input  wire                    mainAboveHigh,
    input  wire                    mainBelowLow,
    input  wire                    backupNoSupply,
    input  wire                    senseAboveCharged,
    input  wire                    senseAboveHysteresis,
    input  wire                    secondCompOut,
    input  wire [`THR_SEL_W-1:0]   bootChargedSelect,
    input  wire                    sleepRequest,
    input  wire                    cfgWrite,
    input  wire                    powerDownPolarityIn,
    input  wire [`THR_SEL_W-1:0]   chargedSelectIn,
    input  wire [`THR_SEL_W-1:0]   secondSelectIn,
    input  wire                    secondRiseEdgeIn,
    input  wire                    watchdogIrqModeIn,
    input  wire [`WDOG_SEL_W-1:0]  watchdogPeriodIn,
    input  wire                    deviceOnBitIn,
    input  wire                    trackEnableSet,
    input  wire [`CAUSE_W-1:0]     causeClear,
    output reg  [2:0]              powerState_q,
    output reg                     systemResetOut_q,
    output reg                     trackEnable_q,
    output reg  [`CAUSE_W-1:0]     cause_q,
    output reg                     hostInterruptOut_q,
    output reg                     chargedOk_q
);

    reg                    pdPol_q;
    reg [`THR_SEL_W-1:0]   chargedSel_q;
    reg [`THR_SEL_W-1:0]   secondSel_q;
    reg                    secondRise_q;
    reg                    wdogIrqMode_q;
    reg [`WDOG_SEL_W-1:0]  wdogSel_q;
    reg                    devOn_q;
    reg [31:0]             debCnt_q;
    reg [31:0]             holdCnt_q;
    reg [31:0]             wdogCnt_q;
    reg                    second_q;
    reg                    coldPrev_q;
    reg                    btnPrev_q;
    reg [`CAUSE_W-1:0]     causeSet;
    reg [2:0]              state_d;
    wire                   pdActive;
    wire                   holdOn;
    wire                   charged;
    wire                   secondEn;
    wire                   secondTrig;
    wire                   startReason;
    wire                   inRun;
    wire [31:0]            wdogLimit;
    wire                   wdogExpire;
    wire                   turnOff;
    wire                   coldRelease;
    wire                   btnPress;
    wire                   wdogFlag;
    wire                   wdogShutdown;
    wire                   offEntry;
    wire                   secondUp;
    wire                   secondDown;
    wire [`CAUSE_W-1:0]    causeNext;

    function [31:0] period_cycles;
        input [`WDOG_SEL_W-1:0] sel;
        begin
            period_cycles = WDOG_UNIT << sel;
        end
    endfunction

    // count has reached the last cycle of its span
    function count_done;
        input [31:0] cnt;
        input [31:0] span;
        begin
            count_done = (cnt >= span - 32'h1);
        end
    endfunction

    // states in which the host is powered and out of reset
    function is_running;
        input [2:0] st;
        begin
            is_running = (st == `PS_ACTIVE) || (st == `PS_SLEEP);
        end
    endfunction

    assign pdActive   = (powerDownResetIn == pdPol_q);
    assign holdOn     = (holdCnt_q != 32'h0);
    assign charged    = (chargedSel_q == {`THR_SEL_W{1'b0}}) || chargedOk_q;
    assign secondEn   = (secondSel_q != {`THR_SEL_W{1'b0}})
                      && (powerState_q != `PS_BACKUP)
                      && (powerState_q != `PS_NOSUPPLY);
    assign secondUp   = secondEn && secondCompOut && !second_q;
    assign secondDown = secondEn && !secondCompOut && second_q;
    assign secondTrig = secondRise_q ? secondUp : secondDown;
    assign inRun      = is_running(powerState_q);
    assign wdogLimit  = period_cycles(wdogSel_q);
    assign wdogExpire = inRun && systemResetOut_q && count_done(wdogCnt_q, wdogLimit);
    // periodic mode flags the last cycle of every period
    assign wdogFlag   = !wdogIrqMode_q && inRun && systemResetOut_q
                      && (wdogCnt_q == wdogLimit - 32'h1);
    // shut down on expiry in interrupt mode, or at a period end with the flag still set
    assign wdogShutdown = wdogExpire && (wdogIrqMode_q || cause_q[`CAUSE_WDOG]);
    assign btnPress   = btnPrev_q && !powerButtonIn;
    assign coldRelease = coldPrev_q && !coldResetIn;
    // start-up reasons: none counted while a reset input is asserted
    assign startReason = !coldResetIn && !pdActive
                      && (btnPress || devOn_q || secondTrig
                          || (holdOn && hostInterruptOut_q));
    assign turnOff    = inRun && !is_running(state_d);
    assign offEntry   = (powerState_q != `PS_OFF) && (state_d == `PS_OFF);
    // set wins over clear; a cold reset wipes every cause
    assign causeNext  = coldResetIn ? {`CAUSE_W{1'b0}}
                                    : ((cause_q & ~causeClear) | causeSet);

    always @* begin
        causeSet = {`CAUSE_W{1'b0}};
        causeSet[`CAUSE_POWER_DOWN_RESET_IN]  = pdActive && (powerState_q != `PS_NOSUPPLY);
        causeSet[`CAUSE_WDOG]   = wdogExpire || wdogFlag;
        causeSet[`CAUSE_MAINHI] = (powerState_q == `PS_NOSUPPLY) && mainAboveHigh;
        causeSet[`CAUSE_RISE2]  = secondTrig && secondRise_q;
        causeSet[`CAUSE_FALL2]  = secondTrig && !secondRise_q;
    end

    // next power state; supply events outrank the reset inputs
    always @* begin
        state_d = powerState_q;
        if (backupNoSupply && mainBelowLow) begin
            state_d = `PS_NOSUPPLY;
        end else if (powerState_q == `PS_NOSUPPLY) begin
            if (mainAboveHigh) begin
                state_d = `PS_OFF;
            end
        end else if (mainBelowLow) begin
            state_d = `PS_BACKUP;
        end else if (coldResetIn || pdActive) begin
            state_d = `PS_OFF;
        end else begin
            case (powerState_q)
                `PS_BACKUP: begin
                    state_d = `PS_OFF;
                end
                `PS_OFF: begin
                    if ((startReason || coldRelease) && charged) begin
                        state_d = `PS_ACTIVE;
                    end
                end
                `PS_ACTIVE: begin
                    if (wdogShutdown) begin
                        state_d = `PS_OFF;
                    end else if (!(startReason || holdOn || devOn_q)) begin
                        state_d = `PS_OFF;
                    end else if (sleepRequest) begin
                        state_d = `PS_SLEEP;
                    end
                end
                `PS_SLEEP: begin
                    if (wdogShutdown) begin
                        state_d = `PS_OFF;
                    end else if (!sleepRequest || secondTrig || btnPress) begin
                        state_d = `PS_ACTIVE;
                    end
                end
                default: begin
                    state_d = `PS_OFF;
                end
            endcase
        end
    end

    // power state
    always @(posedge clk) begin
        if (reset) begin
            powerState_q <= `PS_NOSUPPLY;
        end else begin
            powerState_q <= state_d;
        end
    end

    // system reset output: released only while the host is running
    always @(posedge clk) begin
        if (reset) begin
            systemResetOut_q <= 1'b0;
        end else begin
            systemResetOut_q <= is_running(state_d);
        end
    end

    // last sampled level of the edge-sensitive inputs
    always @(posedge clk) begin
        if (reset) begin
            second_q   <= 1'b0;
            coldPrev_q <= 1'b0;
            btnPrev_q  <= 1'b1;
        end else begin
            second_q   <= secondCompOut;
            coldPrev_q <= coldResetIn;
            btnPrev_q  <= powerButtonIn;
        end
    end

    // interrupt causes
    always @(posedge clk) begin
        if (reset) begin
            cause_q <= {`CAUSE_W{1'b0}};
        end else begin
            cause_q <= causeNext;
        end
    end

    // host interrupt line follows the causes in the same cycle
    always @(posedge clk) begin
        if (reset) begin
            hostInterruptOut_q <= 1'b0;
        end else begin
            hostInterruptOut_q <= |causeNext;
        end
    end

    // configuration bits: a cold reset restores them and wins over a write
    always @(posedge clk) begin
        if (reset) begin
            pdPol_q       <= `PD_POL_RESET;
            chargedSel_q  <= {`THR_SEL_W{1'b0}};
            secondSel_q   <= `SECOND_SEL_RESET;
            secondRise_q  <= 1'b0;
            wdogIrqMode_q <= 1'b0;
            wdogSel_q     <= `WDOG_SEL_RESET;
            devOn_q       <= 1'b0;
        end else if (coldResetIn) begin
            pdPol_q       <= `PD_POL_RESET;
            chargedSel_q  <= bootChargedSelect;
            secondSel_q   <= `SECOND_SEL_RESET;
            secondRise_q  <= 1'b0;
            wdogIrqMode_q <= 1'b0;
            wdogSel_q     <= `WDOG_SEL_RESET;
            devOn_q       <= 1'b0;
        end else if (cfgWrite) begin
            pdPol_q       <= powerDownPolarityIn;
            chargedSel_q  <= chargedSelectIn;
            secondSel_q   <= secondSelectIn;
            secondRise_q  <= secondRiseEdgeIn;
            wdogIrqMode_q <= watchdogIrqModeIn;
            wdogSel_q     <= watchdogPeriodIn;
            devOn_q       <= deviceOnBitIn;
        end
    end

    // tracking enable: any turn-off, or a cold reset, returns it to zero
    always @(posedge clk) begin
        if (reset) begin
            trackEnable_q <= 1'b0;
        end else if (turnOff || coldResetIn) begin
            trackEnable_q <= 1'b0;
        end else if (trackEnableSet) begin
            trackEnable_q <= 1'b1;
        end
    end

    // hold window: started by cold reset release and by every entry to off
    always @(posedge clk) begin
        if (reset) begin
            holdCnt_q <= 32'h0;
        end else if (coldRelease) begin
            holdCnt_q <= HOLD_CYCLES;
        end else if (offEntry) begin
            holdCnt_q <= HOLD_CYCLES;
        end else if (holdOn) begin
            holdCnt_q <= holdCnt_q - 32'h1;
        end
    end

    // charged result: accepted only after an unbroken run above hysteresis
    always @(posedge clk) begin
        if (reset) begin
            debCnt_q    <= 32'h0;
            chargedOk_q <= 1'b0;
        end else if (!senseAboveHysteresis) begin
            debCnt_q    <= 32'h0;
            chargedOk_q <= 1'b0;
        end else if (count_done(debCnt_q, DEB_CYCLES)) begin
            chargedOk_q <= senseAboveCharged || chargedOk_q;
        end else begin
            debCnt_q    <= debCnt_q + 32'h1;
        end
    end

    // watchdog counter: periodic or pending-interrupt timing
    always @(posedge clk) begin
        if (reset) begin
            wdogCnt_q <= 32'h0;
        end else if (!systemResetOut_q) begin
            wdogCnt_q <= 32'h0;
        end else if (wdogIrqMode_q) begin
            if (!hostInterruptOut_q || (|causeClear)) begin
                wdogCnt_q <= 32'h0;
            end else begin
                wdogCnt_q <= wdogCnt_q + 32'h1;
            end
        end else if (count_done(wdogCnt_q, wdogLimit)) begin
            wdogCnt_q <= 32'h0;
        end else begin
            wdogCnt_q <= wdogCnt_q + 32'h1;
        end
    end

endmodule

// File: bench/power_event_host.sv
`timescale 1ns/1ps
module power_event_host #(
    parameter SETTLE = 8
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       hostInterruptOut_q,
    input  wire logic [4:0] cause_q,
    input  wire logic       systemResetOut_q,
    input  wire logic       clearEn,
    input  wire logic [3:0] clearDelay,
    input  wire logic       trackReq,
    output logic      [4:0] causeClear,
    output logic            trackEnableSet
);
    int waitCnt;
    int onCnt;
    initial begin
        causeClear = 5'h00;
        trackEnableSet = 1'h0;
    end
    // host answers a pending interrupt after clearDelay cycles by clearing every pending cause
    always @(negedge clk) begin
        causeClear <= 5'h00;
        trackEnableSet <= 1'h0;
        onCnt <= systemResetOut_q ? onCnt + 1 : 0;
        if (trackReq && onCnt == SETTLE)
            trackEnableSet <= 1'h1;
        if (reset || !clearEn || !hostInterruptOut_q || causeClear != 5'h00)
            waitCnt <= 0;
        else if (waitCnt == clearDelay)
            causeClear <= cause_q;
        else
            waitCnt <= waitCnt + 1;
    end
endmodule

// File: bench/power_event_supervisor_chk.sv
`timescale 1ns/1ps
`include "power_event_defs.vh"
module power_event_supervisor_chk (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  coldResetIn,
    input wire logic                  powerDownResetIn,
    input wire logic                  mainAboveHigh,
    input wire logic                  mainBelowLow,
    input wire logic                  backupNoSupply,
    input wire logic [`THR_SEL_W-1:0] bootChargedSelect,
    input wire logic                  cfgWrite,
    input wire logic                  powerDownPolarityIn,
    input wire logic                  trackEnableSet,
    input wire logic [2:0]            powerState_q,
    input wire logic                  systemResetOut_q,
    input wire logic                  trackEnable_q,
    input wire logic [`CAUSE_W-1:0]   cause_q,
    input wire logic                  hostInterruptOut_q
);
    logic pol_q;
    wire  pdOn = (powerDownResetIn == pol_q);
    always @(posedge clk) begin
        if (reset || coldResetIn)
            pol_q <= `PD_POL_RESET;
        else if (cfgWrite)
            pol_q <= powerDownPolarityIn;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence mainHighSeen;
        powerState_q == `PS_OFF && cause_q[`CAUSE_MAINHI] ##1 hostInterruptOut_q;
    endsequence
    AST_COLD_OFF: assert property (coldResetIn |=> powerState_q == `PS_OFF)
        else $error("cold reset did not hold off state");
    AST_COLD_UP: assert property ($fell(coldResetIn) && powerState_q == `PS_OFF && !pdOn
        && $past(bootChargedSelect) == 0 && !mainBelowLow |=> systemResetOut_q)
        else $error("cold reset release did not turn on");
    AST_PD_OFF: assert property (pdOn |=> !systemResetOut_q)
        else $error("power down input did not force off");
    AST_PD_CAUSE: assert property (pdOn && !coldResetIn && powerState_q == `PS_ACTIVE
        |=> cause_q[`CAUSE_POWER_DOWN_RESET_IN])
        else $error("power down cause missing");
    AST_MAIN_HIGH: assert property (powerState_q == `PS_NOSUPPLY && mainAboveHigh && !coldResetIn
        && !mainBelowLow && !backupNoSupply |=> mainHighSeen)
        else $error("main supply high sequence wrong");
    AST_BACKUP: assert property (mainBelowLow && !backupNoSupply && !coldResetIn && !pdOn
        && powerState_q inside {`PS_OFF, `PS_ACTIVE, `PS_SLEEP} |=> powerState_q == `PS_BACKUP)
        else $error("backup state not entered");
    AST_NO_SUPPLY: assert property (mainBelowLow && backupNoSupply && !coldResetIn
        |=> powerState_q == `PS_NOSUPPLY)
        else $error("no supply state not entered");
    AST_TRACK_CLR: assert property ($fell(systemResetOut_q) && !$past(trackEnableSet)
        |-> !trackEnable_q)
        else $error("tracking enable survived turn off");
    AST_IRQ_OUT: assert property (hostInterruptOut_q == |cause_q)
        else $error("interrupt output disagrees with causes");
endmodule
bind power_event_supervisor power_event_supervisor_chk chk (.clk, .reset, .coldResetIn,
    .powerDownResetIn, .mainAboveHigh, .mainBelowLow, .backupNoSupply, .bootChargedSelect,
    .cfgWrite, .powerDownPolarityIn, .trackEnableSet, .powerState_q, .systemResetOut_q,
    .trackEnable_q, .cause_q, .hostInterruptOut_q);

// File: bench/pmic_power_event_supervisor_test.sv
`timescale 1ns/1ps
`include "power_event_defs.vh"
module pmic_power_event_supervisor_test;
    localparam HOLD = 16;
    logic clk, reset, coldResetIn, powerDownResetIn, powerButtonIn, mainAboveHigh, mainBelowLow;
    logic backupNoSupply, senseAboveCharged, senseAboveHysteresis, secondCompOut, sleepRequest;
    logic cfgWrite, powerDownPolarityIn, secondRiseEdgeIn, watchdogIrqModeIn, deviceOnBitIn;
    logic clearEn, trackReq, trackEnableSet, systemResetOut_q, trackEnable_q;
    logic hostInterruptOut_q, chargedOk_q;
    logic [4:0] bootChargedSelect, chargedSelectIn, secondSelectIn, causeClear, cause_q;
    logic [1:0] watchdogPeriodIn;
    logic [3:0] clearDelay;
    logic [2:0] powerState_q;
    int         bad_count, n_checks;
    power_event_supervisor #(.HOLD_CYCLES(HOLD), .WDOG_UNIT(8), .DEB_CYCLES(4)) DUT (.clk, .reset,
        .coldResetIn, .powerDownResetIn, .powerButtonIn, .mainAboveHigh, .mainBelowLow,
        .backupNoSupply, .senseAboveCharged, .senseAboveHysteresis, .secondCompOut,
        .bootChargedSelect, .sleepRequest, .cfgWrite, .powerDownPolarityIn, .chargedSelectIn,
        .secondSelectIn, .secondRiseEdgeIn, .watchdogIrqModeIn, .watchdogPeriodIn, .deviceOnBitIn,
        .trackEnableSet, .causeClear, .powerState_q, .systemResetOut_q, .trackEnable_q, .cause_q,
        .hostInterruptOut_q, .chargedOk_q);
    power_event_host host (.clk, .reset, .hostInterruptOut_q, .cause_q, .systemResetOut_q,
        .clearEn, .clearDelay, .trackReq, .causeClear, .trackEnableSet);
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [4:0] act, input logic [4:0] exp, input string what);
        n_checks++;
        if (act !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, act, exp);
        end
    endtask
    task automatic waitState(input logic [2:0] exp, input int maxCyc, input string what);
        for (int i = 0; i < maxCyc && powerState_q !== exp; i++) @(negedge clk);
        chk(powerState_q, exp, what);
    endtask
    task automatic cfg(input logic on, input logic rise, input logic irq, input logic [1:0] per,
                       input logic [4:0] sel2);
        @(negedge clk);
        {deviceOnBitIn, secondRiseEdgeIn, watchdogIrqModeIn} = {on, rise, irq};
        {watchdogPeriodIn, secondSelectIn} = {per, sel2};
        cfgWrite = 1'h1;
        @(negedge clk);
        cfgWrite = 1'h0;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #(6000 * 25);
        bad_count++;
        $display("MISMATCH t=%0t run did not complete", $time);
        finish_test();
    end
    initial begin
        {reset, coldResetIn, mainAboveHigh, mainBelowLow, backupNoSupply, secondCompOut} = 6'h20;
        {powerDownResetIn, powerButtonIn, sleepRequest, cfgWrite, powerDownPolarityIn} = 5'h18;
        {senseAboveCharged, senseAboveHysteresis, clearEn, trackReq, clearDelay} = 8'h06;
        {bootChargedSelect, chargedSelectIn, secondSelectIn} = 15'h0000;
        {secondRiseEdgeIn, watchdogIrqModeIn, watchdogPeriodIn, deviceOnBitIn} = 5'h00;
        repeat (2) @(negedge clk);
        reset = 1'h0;
        mainAboveHigh = 1'h1;
        @(negedge clk);
        chk({powerState_q, cause_q[`CAUSE_MAINHI]}, {`PS_OFF, 1'h1}, "main high");
        @(negedge clk);
        chk(hostInterruptOut_q, 1'h1, "interrupt");
        $display("test main_high done");
        coldResetIn = 1'h1;
        repeat (2) @(negedge clk);
        chk({powerState_q, trackEnable_q}, {`PS_OFF, 1'h0}, "cold hold");
        {coldResetIn, clearEn} = 2'h1;
        @(negedge clk);
        chk(systemResetOut_q, 1'h1, "cold release");
        repeat (HOLD - 4) @(negedge clk);
        chk(powerState_q, `PS_ACTIVE, "inside hold window");
        waitState(`PS_OFF, 12, "after hold window");
        chk(chargedOk_q, 1'h0, "not charged");
        {senseAboveCharged, senseAboveHysteresis, trackReq} = 3'h7;
        cfg(1'h1, 1'h0, 1'h0, 2'h3, 5'h00);
        waitState(`PS_ACTIVE, 8, "device on");
        repeat (12) @(negedge clk);
        chk({chargedOk_q, trackEnable_q}, 2'h3, "charged and tracking");
        {powerDownResetIn, clearEn} = 2'h0;
        repeat (2) @(negedge clk);
        chk({powerState_q, trackEnable_q, cause_q[`CAUSE_POWER_DOWN_RESET_IN]}, {`PS_OFF, 2'h1}, "pd");
        repeat (10) @(negedge clk);
        chk(powerState_q, `PS_OFF, "held off");
        {powerDownResetIn, clearEn, trackReq} = 3'h6;
        waitState(`PS_ACTIVE, 8, "restart");
        $display("test cold_and_power_down done");
        repeat (200) @(negedge clk);
        chk(systemResetOut_q, 1'h1, "serviced watchdog");
        clearEn = 1'h0;
        waitState(`PS_OFF, 200, "watchdog expiry");
        chk(cause_q[`CAUSE_WDOG], 1'h1, "watchdog cause");
        cfg(1'h0, 1'h1, 1'h1, 2'h0, 5'h00);
        waitState(`PS_OFF, 40, "interrupt mode expiry");
        $display("test watchdog done");
        clearEn = 1'h1;
        repeat (40) @(negedge clk);
        secondCompOut = 1'h1;
        repeat (3) @(negedge clk);
        chk({powerState_q, cause_q}, {`PS_OFF, 5'h00}, "second disabled");
        for (int m = 0; m < 2; m++) begin
            clearEn = 1'h0;
            cfg(1'h0, m[0], 1'h1, 2'h0, 5'h01);
            secondCompOut = m[0];
            repeat (2) @(negedge clk);
            chk(cause_q[4 - m], 1'h1, "second edge");
            waitState(`PS_ACTIVE, 8, "second wake");
            waitState(`PS_OFF, 40, "pending expiry");
            clearEn = 1'h1;
            repeat (20) @(negedge clk);
        end
        $display("test second_comparator done");
        {mainAboveHigh, mainBelowLow} = 2'h1;
        repeat (2) @(negedge clk);
        chk(powerState_q, `PS_BACKUP, "backup");
        backupNoSupply = 1'h1;
        @(negedge clk);
        chk(powerState_q, `PS_NOSUPPLY, "no supply");
        $display("test supply_loss done");
        finish_test();
    end
endmodule
